// ==== pkg/caf_pkg.sv ====
/* constants of the camera acquisition front end.
   assumes a 40 MHz block clock and a 32-bit register port. */
package caf_pkg;
    localparam int NPORT = 2;
    localparam int NTRIG = 8;
    localparam int NTAP = 3;
    localparam int CLK_NS = 25;
    // --------------------
    // register offsets (byte addresses)
    // --------------------
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_STAT = 6'h04;
    localparam logic [5:0] REG_FMT = 6'h08;
    localparam logic [5:0] REG_WPIX = 6'h0c;
    localparam logic [5:0] REG_WLIN = 6'h10;
    localparam logic [5:0] REG_RPIX = 6'h14;
    localparam logic [5:0] REG_RLIN = 6'h18;
    localparam logic [5:0] REG_TGEN = 6'h1c;
    localparam logic [5:0] REG_TRG = 6'h20;
    localparam logic [7:0] REG_ENC_CTRL = 8'h80;
    localparam logic [7:0] REG_ENC_DIV = 8'h84;
    localparam logic [7:0] REG_POS_LO = 8'h88;
    localparam logic [7:0] REG_POS_HI = 8'h8c;
    // --------------------
    // field positions
    // --------------------
    localparam int CTL_START = 0;
    localparam int CTL_STOP = 1;
    localparam int CTL_TEN = 2;
    localparam int CTL_TSEL = 3;
    localparam int CTL_TEDGE = 6;
    localparam int CTL_NFR = 16;
    localparam int FMT_DEPTH = 0;
    localparam int FMT_ORD = 3;
    localparam int FMT_HDIR = 9;
    localparam int FMT_VDIR = 12;
    localparam int TC_DIR = 0;
    localparam int TC_POL = 1;
    localparam int TC_LVL = 2;
    localparam int TC_SRC = 3;
    localparam int TC_FILT = 6;
    localparam int ENC_FILT = 0;
    localparam int ENC_CLR = 1;
    // --------------------
    // reset values
    // --------------------
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [31:0] WIN_RST = 32'hffff_0000;
    localparam logic [31:0] FMT_RST = 32'h0000_0090;
    // --------------------
    // trigger output sources and acquisition states
    // --------------------
    localparam logic [2:0] SRC_LEVEL = 3'h0;
    localparam logic [2:0] SRC_TGEN0 = 3'h1;
    localparam logic [2:0] SRC_TGEN1 = 3'h2;
    localparam logic [2:0] SRC_BUSY0 = 3'h3;
    localparam logic [2:0] SRC_BUSY1 = 3'h4;
    localparam logic [2:0] SRC_ENC = 3'h5;
    typedef enum logic [1:0] {
        ACQ_IDLE = 2'b00,
        ACQ_ARM = 2'b01,
        ACQ_RUN = 2'b10
    } caf_acq_e;
    // --------------------
    // timing
    // --------------------
    localparam int FILT_NS = 200;
    localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ==== verilog/caf_front_end.sv ====
/*
 * dual-port camera acquisition front end: video window and region of
 * interest, tap reordering, acquisition start, shared trigger lines,
 * timing pulse generators and quadrature position counter.
 * assumes camera pins and trigger pins are asynchronous to clock and
 * a pixel clock well below a quarter of the block clock.
 */
// What this block does
// - each tap scans left/right and top/bottom independently
// - bit depth and tap order are kept per port
// - each trigger line starts acquisition on rising or falling edge
// - each trigger line can be driven asserted or unasserted as output
// - timing pulses or status signals map onto any trigger line
// - seven sync bus lines plus one external, polarity and direction each
// - both ports configure, read and drive every trigger line
// - the most recent assignment of a line wins, from either port
// - selectable noise filter on every trigger input
// - pixel start and count counted from line-valid assertion
// - line start and count counted from frame-valid assertion
// - second region selects pixels inside region and window
// - only active pixels pass to the tap reordering stage
// - software start captures a set number of frames, then stops
// - each port owns its exposure and frame-rate pulse generator
// - quadrature phases decode into a 64-bit position
// - position ticks divided down into a pulse train
// - position count readable at any time
// - selectable noise filter on both encoder phases
`timescale 1ns/1ps
`default_nettype none
module caf_front_end
    import caf_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [NPORT-1:0] cam_pclk,
    input wire logic [NPORT-1:0] cam_fval,
    input wire logic [NPORT-1:0] cam_lval,
    input wire logic [NPORT-1:0][23:0] cam_data,
    output logic [NPORT-1:0] pix_valid,
    output logic [NPORT-1:0][23:0] pix_data,
    output logic [NPORT-1:0][NTAP-1:0][15:0] pix_x,
    output logic [NPORT-1:0][NTAP-1:0][15:0] pix_y,
    output logic [NPORT-1:0] acq_busy,
    output logic [NPORT-1:0] tgen_out,
    input wire logic [NTRIG-1:0] trig_in,
    output logic [NTRIG-1:0] trig_out,
    output logic [NTRIG-1:0] trig_oe,
    input wire logic enc_a,
    input wire logic enc_b,
    output logic enc_pulse
);
    // --------------------
    // register decode
    // --------------------
    logic [31:0] cfg_r [NPORT][8];
    logic [7:0] tcfg_r [NTRIG];
    logic [1:0] enc_ctl_r;
    logic [15:0] enc_div_r;
    logic [63:0] pos_r;
    logic [31:0] pos_hi_r;
    logic [NPORT-1:0][31:0] stat_w;
    logic [NTRIG-1:0] trg_lvl;
    logic [NTRIG+1:0] clean;
    logic [NTRIG-1:0] clean_d_r;
    wire aligned = (reg_addr[1:0] == 2'b00);
    wire is_port = ~reg_addr[7];
    wire psel = reg_addr[6];
    wire [5:0] loc = reg_addr[5:0];
    wire [2:0] widx = loc[4:2];
    wire wr_cfg = reg_wr & aligned & is_port & ~loc[5] & (loc != REG_STAT);
    wire wr_trg = reg_wr & aligned & is_port & loc[5];
    wire wr_enc = reg_wr & (reg_addr == REG_ENC_CTRL);
    wire wr_div = reg_wr & (reg_addr == REG_ENC_DIV);
    wire rd_lo = reg_rd & (reg_addr == REG_POS_LO);
    wire [31:0] trg_rd = {23'h0, trg_lvl[widx], tcfg_r[widx]};
    wire [31:0] cfg_rd = (loc == REG_STAT) ? stat_w[psel] : cfg_r[psel][widx];
    wire [31:0] port_rd = loc[5] ? trg_rd : cfg_rd;
    wire [31:0] glob_rd =
        (reg_addr == REG_ENC_CTRL) ? {31'h0, enc_ctl_r[ENC_FILT]} :
        (reg_addr == REG_ENC_DIV) ? {16'h0, enc_div_r} :
        (reg_addr == REG_POS_LO) ? pos_r[31:0] :
        (reg_addr == REG_POS_HI) ? pos_hi_r : 32'h0;
    wire [31:0] rd_nxt = ~aligned ? 32'h0 : (is_port ? port_rd : glob_rd);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            reg_rdata <= 32'h0;
        else
            reg_rdata <= reg_rd ? rd_nxt : 32'h0;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            for (int p = 0; p < NPORT; p++)
            begin
                for (int w = 0; w < 8; w++)
                    cfg_r[p][w] <= (w >= 3 && w <= 6) ? WIN_RST : CFG_RST;
                cfg_r[p][2] <= FMT_RST;
            end
        end
        else if (wr_cfg)
            cfg_r[psel][widx] <= reg_wdata;
    end

    // either bank writes the same line table, so the last write wins
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NTRIG; i++)
                tcfg_r[i] <= 8'h0;
        end
        else if (wr_trg)
            tcfg_r[widx] <= reg_wdata[7:0];
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            enc_ctl_r <= 2'b00;
            enc_div_r <= 16'h0;
            pos_hi_r <= 32'h0;
        end
        else
        begin
            if (wr_enc)
                enc_ctl_r <= reg_wdata[1:0];
            if (wr_div)
                enc_div_r <= reg_wdata[15:0];
            if (rd_lo)
                pos_hi_r <= pos_r[63:32];
        end
    end

    // --------------------
    // input noise filters
    // --------------------
    wire [NTRIG+1:0] fin = {enc_b, enc_a, trig_in};
    logic [NTRIG+1:0] fen;
    for (genvar i = 0; i < NTRIG + 2; i++)
    begin : g_filt
        logic s1_r;
        logic s2_r;
        logic st_r;
        logic [3:0] cnt_r;
        if (i < NTRIG)
        begin : g_t
            assign fen[i] = tcfg_r[i][TC_FILT];
        end
        else
        begin : g_e
            assign fen[i] = enc_ctl_r[ENC_FILT];
        end
        wire held = (cnt_r == 4'(FILT_CYC - 1));
        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                s1_r <= 1'b0;
                s2_r <= 1'b0;
                st_r <= 1'b0;
                cnt_r <= 4'h0;
            end
            else
            begin
                s1_r <= fin[i];
                s2_r <= s1_r;
                cnt_r <= (s2_r == st_r || held) ? 4'h0 : cnt_r + 4'h1;
                if (s2_r != st_r && held)
                    st_r <= s2_r;
            end
        end
        assign clean[i] = fen[i] ? st_r : s2_r;
    end

    // --------------------
    // trigger lines
    // --------------------
    logic [NPORT-1:0] tgen_r;
    logic enc_pulse_r;
    for (genvar i = 0; i < NTRIG; i++)
    begin : g_trg
        wire [7:0] srcs = {2'b00, enc_pulse_r, acq_busy[1], acq_busy[0],
                           tgen_r[1], tgen_r[0], tcfg_r[i][TC_LVL]};
        wire pol = tcfg_r[i][TC_POL];
        wire drv = srcs[tcfg_r[i][TC_SRC +: 3]] ^ pol;
        assign trg_lvl[i] = clean[i] ^ pol;
        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                trig_out[i] <= 1'b0;
                trig_oe[i] <= 1'b0;
            end
            else
            begin
                trig_out[i] <= drv;
                trig_oe[i] <= tcfg_r[i][TC_DIR];
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            clean_d_r <= '0;
        else
            clean_d_r <= clean[NTRIG-1:0];
    end

    // ----------------------------------------
    // per-port video path, acquisition and timing
    // ----------------------------------------
    for (genvar p = 0; p < NPORT; p++)
    begin : g_port
        logic [26:0] vs1_r;
        logic [26:0] vs2_r;
        logic pclk_d_r;
        logic fv_d_r;
        logic lv_d_r;
        logic [15:0] pix_r;
        logic [15:0] ln_r;
        logic [15:0] done_r;
        logic [15:0] tcnt_r;
        caf_acq_e st_r;
        caf_acq_e st_nxt;
        wire [31:0] ctl = cfg_r[p][0];
        wire [31:0] fmt = cfg_r[p][2];
        wire [31:0] tg = cfg_r[p][7];
        wire pe = vs2_r[26] & ~pclk_d_r;
        wire fv = vs2_r[25];
        wire lv = vs2_r[24];
        wire [23:0] din = vs2_r[23:0];
        wire fv_rise = fv & ~fv_d_r;
        wire fv_fall = ~fv & fv_d_r;
        wire lv_rise = pe & lv & ~lv_d_r;
        wire lv_fall = pe & ~lv & lv_d_r;
        wire [15:0] xi = lv_rise ? 16'h0 : pix_r;
        wire [15:0] yi = fv_rise ? 16'h0 : ln_r;
        wire [15:0] xw = xi - cfg_r[p][3][15:0];
        wire [15:0] yw = yi - cfg_r[p][4][15:0];
        wire [15:0] xr = xw - cfg_r[p][5][15:0];
        wire [15:0] yr = yw - cfg_r[p][6][15:0];
        wire in_wx = xi >= cfg_r[p][3][15:0] && xw < cfg_r[p][3][31:16];
        wire in_wy = yi >= cfg_r[p][4][15:0] && yw < cfg_r[p][4][31:16];
        wire in_rx = xw >= cfg_r[p][5][15:0] && xr < cfg_r[p][5][31:16];
        wire in_ry = yw >= cfg_r[p][6][15:0] && yr < cfg_r[p][6][31:16];
        wire take = pe & lv & fv & (st_r == ACQ_RUN) & in_wx & in_wy & in_rx & in_ry;
        wire tl = trg_lvl[ctl[CTL_TSEL +: 3]];
        wire cl = clean[ctl[CTL_TSEL +: 3]];
        wire cd = clean_d_r[ctl[CTL_TSEL +: 3]];
        wire t_edge = ctl[CTL_TEDGE] ? (~cl & cd) : (cl & ~cd);
        wire sw_go = wr_cfg & (psel == 1'(p)) & (loc == REG_CTRL) & reg_wdata[CTL_START];
        wire sw_stop = wr_cfg & (psel == 1'(p)) & (loc == REG_CTRL) & reg_wdata[CTL_STOP];
        wire go = sw_go | (ctl[CTL_TEN] & t_edge);
        wire [15:0] nfr = ctl[CTL_NFR +: 16];
        wire last = (nfr != 16'h0) && (done_r + 16'h1 == nfr);
        logic [23:0] mask;
        logic [23:0] ord_d;

        always_comb
        begin
            st_nxt = st_r;
            unique case (st_r)
                ACQ_IDLE: if (go) st_nxt = ACQ_ARM;
                ACQ_ARM: if (fv_rise) st_nxt = ACQ_RUN;
                ACQ_RUN: if (fv_fall && last) st_nxt = ACQ_IDLE;
                default: st_nxt = ACQ_IDLE;
            endcase
            if (sw_stop)
                st_nxt = ACQ_IDLE;
        end

        // depth mask and lane order for the reordering stage
        always_comb
        begin
            unique case (fmt[FMT_DEPTH +: 3])
                3'h0: mask = 24'h0000ff;
                3'h1: mask = 24'h0003ff;
                3'h2: mask = 24'h000fff;
                3'h3: mask = 24'h003fff;
                3'h4: mask = 24'h00ffff;
                default: mask = 24'hffffff;
            endcase
            for (int t = 0; t < NTAP; t++)
                ord_d[t*8 +: 8] = din[fmt[FMT_ORD + 2*t +: 2]*8 +: 8];
        end

        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                vs1_r <= '0;
                vs2_r <= '0;
                pclk_d_r <= 1'b0;
                fv_d_r <= 1'b0;
                lv_d_r <= 1'b0;
                pix_r <= 16'h0;
                ln_r <= 16'h0;
            end
            else
            begin
                vs1_r <= {cam_pclk[p], cam_fval[p], cam_lval[p], cam_data[p]};
                vs2_r <= vs1_r;
                pclk_d_r <= vs2_r[26];
                fv_d_r <= fv;
                if (fv_rise)
                    ln_r <= 16'h0;
                else if (lv_fall)
                    ln_r <= ln_r + 16'h1;
                if (pe)
                begin
                    lv_d_r <= lv;
                    if (lv)
                        pix_r <= xi + 16'h1;
                end
            end
        end

        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                st_r <= ACQ_IDLE;
                done_r <= 16'h0;
            end
            else
            begin
                st_r <= st_nxt;
                if (st_r == ACQ_ARM && fv_rise)
                    done_r <= 16'h0;
                else if (st_r == ACQ_RUN && fv_fall)
                    done_r <= done_r + 16'h1;
            end
        end

        // pixels are discarded or passed, never held back
        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                pix_valid[p] <= 1'b0;
                pix_data[p] <= 24'h0;
                pix_x[p] <= '0;
                pix_y[p] <= '0;
            end
            else
            begin
                pix_valid[p] <= take;
                if (take)
                begin
                    pix_data[p] <= (fmt[FMT_DEPTH +: 3] == 3'h0) ? ord_d : din & mask;
                    for (int t = 0; t < NTAP; t++)
                    begin
                        pix_x[p][t] <= fmt[FMT_HDIR + t] ?
                            cfg_r[p][5][31:16] - 16'h1 - xr : xr;
                        pix_y[p][t] <= fmt[FMT_VDIR + t] ?
                            cfg_r[p][6][31:16] - 16'h1 - yr : yr;
                    end
                end
            end
        end

        // period in the upper half, high time in the lower half
        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                tcnt_r <= 16'h0;
                tgen_r[p] <= 1'b0;
            end
            else if (tg[31:16] == 16'h0)
            begin
                tcnt_r <= 16'h0;
                tgen_r[p] <= 1'b0;
            end
            else
            begin
                tcnt_r <= (tcnt_r >= tg[31:16] - 16'h1) ? 16'h0 : tcnt_r + 16'h1;
                tgen_r[p] <= tcnt_r < tg[15:0];
            end
        end

        assign stat_w[p] = {done_r, 14'h0, st_r};
        assign acq_busy[p] = (st_r != ACQ_IDLE);
    end
    assign tgen_out = tgen_r;

    // ----------------------------------------
    // quadrature position counter
    // ----------------------------------------
    logic qa_r;
    logic qb_r;
    logic [15:0] dcnt_r;
    wire qa = clean[NTRIG];
    wire qb = clean[NTRIG+1];
    wire step = (qa ^ qa_r) ^ (qb ^ qb_r);
    wire up = qa ^ qb_r;
    wire dwrap = (dcnt_r + 16'h1 >= enc_div_r);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            qa_r <= 1'b0;
            qb_r <= 1'b0;
            pos_r <= 64'h0;
            dcnt_r <= 16'h0;
            enc_pulse_r <= 1'b0;
        end
        else
        begin
            qa_r <= qa;
            qb_r <= qb;
            enc_pulse_r <= 1'b0;
            if (wr_enc && reg_wdata[ENC_CLR])
                pos_r <= 64'h0;
            else if (step)
                pos_r <= up ? pos_r + 64'h1 : pos_r - 64'h1;
            if (step && enc_div_r != 16'h0)
            begin
                dcnt_r <= dwrap ? 16'h0 : dcnt_r + 16'h1;
                enc_pulse_r <= dwrap;
            end
        end
    end
    assign enc_pulse = enc_pulse_r;
endmodule
`default_nettype wire

// ==== sim/caf_front_end_properties.sv ====
/* checker on the ports of caf_front_end, bound below.
   assumes reset held over at least one clock edge. */
`timescale 1ns/1ps
`default_nettype none
module caf_front_end_chk
    import caf_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [NPORT-1:0] pix_valid,
    input wire logic [NPORT-1:0][23:0] pix_data,
    input wire logic [NPORT-1:0] acq_busy,
    input wire logic [NTRIG-1:0] trig_oe,
    input wire logic enc_pulse
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // ------------------------------
    // assertions
    // ------------------------------
    chk_rd_idle_zero:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("stray read data");
    chk_rd_unmapped:
    assert property (reg_rd && reg_addr >= 8'h90 |=> reg_rdata == 32'h0)
        else $error("unmapped read");
    chk_rd_unaligned:
    assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0)
        else $error("unaligned read");
    chk_pix_pulse:
    assert property ((pix_valid & $past(pix_valid)) == 2'h0)
        else $error("long pixel strobe");
    chk_pix_hold:
    assert property (!pix_valid[0] |-> $stable(pix_data[0]))
        else $error("pixel data moved");
    chk_pix_busy:
    assert property ((pix_valid & ~$past(acq_busy)) == 2'h0)
        else $error("pixel while idle");
    chk_enc_pulse:
    assert property (enc_pulse |=> !enc_pulse)
        else $error("long encoder pulse");
    chk_oe_cause:
    assert property ($changed(trig_oe) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("enable changed unasked");
    cover property (pix_valid[0]);
    cover property (enc_pulse);
    cover property ($rose(acq_busy[1]));
endmodule
bind caf_front_end caf_front_end_chk u_chk (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_valid(pix_valid),
    .pix_data(pix_data), .acq_busy(acq_busy), .trig_oe(trig_oe), .enc_pulse(enc_pulse));
`default_nettype wire

// ==== sim/caf_cam_model.sv ====
/* behavioural camera for one port: a frame of npix by nlin pixels per go.
   assumes go rises only while idle is high; pixel clock 200 ns. */
`timescale 1ns/1ps
`default_nettype none
module caf_cam_model
(
    input wire logic go,
    input wire logic [7:0] npix,
    input wire logic [7:0] nlin,
    output logic pclk,
    output logic fval,
    output logic lval,
    output logic [23:0] data,
    output logic idle
);
    initial
    begin
        pclk = 1'b0;
        fval = 1'b0;
        lval = 1'b0;
        data = 24'h5a5a5a;
        idle = 1'b1;
    end
    // one pixel clock; blank words carry the inverse of the last word
    task automatic tick(input logic lv, input logic [23:0] d);
    begin
        lval = lv;
        data = lv ? d : ~data;
        #100 pclk = 1'b1;
        #100 pclk = 1'b0;
    end
    endtask
    // pixel clock stands still outside frames
    always @(posedge go)
    begin
        idle = 1'b0;
        fval = 1'b1;
        for (int l = 0; l < nlin; l++)
        begin
            tick(1'b0, 24'h0);
            for (int p = 0; p < npix; p++)
                tick(1'b1, {8'ha5, l[7:0], p[7:0]});
            tick(1'b0, 24'h0);
        end
        fval = 1'b0;
        idle = 1'b1;
    end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
/* self-checking bench for caf_front_end: registers, video, triggers, encoder.
   assumes caf_cam_model on both camera ports and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import caf_pkg::*;
;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} caf_row_s;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    wire [NPORT-1:0] cam_pclk, cam_fval, cam_lval, idle;
    wire [NPORT-1:0][23:0] cam_data;
    logic [NPORT-1:0] go = 2'h0;
    logic [NPORT-1:0] pix_valid, acq_busy, tgen_out;
    logic [NPORT-1:0][23:0] pix_data;
    logic [NPORT-1:0][NTAP-1:0][15:0] pix_x, pix_y;
    logic [NTRIG-1:0] trig_in, trig_out, trig_oe;
    logic [NTRIG-1:0] trig_ext = 8'h00;
    logic enc_a = 1'b0;
    logic enc_b = 1'b0;
    logic enc_pulse;
    logic [1:0] ph = 2'h0;
    logic [23:0] got0 [$];
    logic [31:0] got1 [$];
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    int np = 0;
    int k = 0, m = 0, n = 0;
    caf_row_s rows [28] = '{'{0, 8'h00, 32'h0}, '{0, 8'h04, 32'h0}, '{0, 8'h08, 32'h90},
        '{0, 8'h0c, WIN_RST}, '{0, 8'h10, WIN_RST}, '{0, 8'h14, WIN_RST},
        '{0, 8'h18, WIN_RST}, '{0, 8'h1c, 32'h0}, '{0, 8'h20, 32'h0},
        '{0, 8'h48, 32'h90}, '{0, 8'h84, 32'h0}, '{0, 8'h8c, 32'h0}, '{0, 8'h90, 32'h0},
        '{0, 8'h0d, 32'h0}, '{1, 8'h44, 32'hffffffff}, '{0, 8'h44, 32'h0},
        '{1, 8'h0c, 32'h00080002}, '{1, 8'h10, 32'h00040001}, '{1, 8'h14, 32'h00030001},
        '{1, 8'h18, 32'h00020001}, '{1, 8'h08, 32'h5}, '{1, 8'h4c, 32'h00040000},
        '{1, 8'h48, 32'h1201}, '{0, 8'h0c, 32'h00080002}, '{0, 8'h4c, 32'h00040000},
        '{0, 8'h48, 32'h1201}, '{1, 8'h94, 32'h12345678}, '{0, 8'h94, 32'h0}};
    assign trig_in = (trig_oe & trig_out) | (~trig_oe & trig_ext);
    caf_cam_model cam0 (.go(go[0]), .npix(8'h0c), .nlin(8'h06), .pclk(cam_pclk[0]),
        .fval(cam_fval[0]), .lval(cam_lval[0]), .data(cam_data[0]), .idle(idle[0]));
    caf_cam_model cam1 (.go(go[1]), .npix(8'h04), .nlin(8'h02), .pclk(cam_pclk[1]),
        .fval(cam_fval[1]), .lval(cam_lval[1]), .data(cam_data[1]), .idle(idle[1]));
    caf_front_end dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cam_pclk(cam_pclk),
        .cam_fval(cam_fval), .cam_lval(cam_lval), .cam_data(cam_data), .pix_valid(pix_valid),
        .pix_data(pix_data), .pix_x(pix_x), .pix_y(pix_y), .acq_busy(acq_busy),
        .tgen_out(tgen_out),
        .trig_in(trig_in), .trig_out(trig_out), .trig_oe(trig_oe), .enc_a(enc_a),
        .enc_b(enc_b), .enc_pulse(enc_pulse));
    // ------------------------------
    // clock, monitor and tasks
    // ------------------------------
    initial
        forever #12.5 clock = ~clock;
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (pix_valid[0] === 1'b1)
            got0.push_back(pix_data[0]);
        if (pix_valid[1] === 1'b1)
            got1.push_back({pix_x[1][0][7:0], pix_y[1][0][7:0], pix_data[1][15:0]});
        if (enc_pulse === 1'b1)
            np++;
        if (cyc == 20000)
        begin
            fails++;
            results();
        end
    end
    task automatic results();
    begin
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    begin
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        check(reg_rdata, exp);
        @(posedge clock);
    end
    endtask
    task automatic frame();
    begin
        @(posedge clock);
        go <= 2'h3;
        @(posedge clock);
        go <= 2'h0;
        for (int i = 0; i < 3000 && idle !== 2'h3; i++)
            @(posedge clock);
        repeat (10) @(posedge clock);
    end
    endtask
    // forward quadrature order ab: 00, 10, 11, 01
    task automatic step(input logic [1:0] dir);
    begin
        ph = ph + dir;
        enc_a <= ph[0] ^ ph[1];
        enc_b <= ph[1];
        repeat (20) @(posedge clock);
    end
    endtask
    // ------------------------------
    // main sequence
    // ------------------------------
    initial
    begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            else
                rchk(rows[i].a, rows[i].d);
        end
        wr(8'h00, 32'h00010001);
        wr(8'h40, 32'h00010001);
        @(negedge clock);
        check(acq_busy, 2'h3);
        frame();
        frame();
        check(got0.size(), 6);
        for (int i = 0; i < 6; i++)
            check(got0[i], {8'ha5, 8'(2 + i / 3), 8'(3 + i % 3)});
        check(got1.size(), 8);
        for (int i = 0; i < 8; i++)
            check(got1[i], {8'(254 - i % 4), 8'(254 - i / 4),
                16'(((i / 4) << 8) | (i % 4))});
        rchk(8'h04, 32'h00010000);
        wr(8'h2c, 32'h5);
        repeat (4) @(posedge clock);
        check({trig_oe[3], trig_out[3]}, 2'h3);
        wr(8'h2c, 32'h7);
        repeat (4) @(posedge clock);
        check({trig_oe[3], trig_out[3]}, 2'h2);
        wr(8'h6c, 32'h0);
        repeat (4) @(posedge clock);
        check(trig_oe[3], 1'b0);
        rchk(8'h2c, 32'h0);
        trig_ext[5] <= 1'b1;
        repeat (20) @(posedge clock);
        rchk(8'h74, 32'h100);
        wr(8'h1c, 32'h000a0003);
        wr(8'h20, 32'h9);
        repeat (20) @(posedge clock);
        repeat (100)
        begin
            @(posedge clock);
            k += tgen_out[0];
            m += trig_out[0];
            n += tgen_out[1];
        end
        check(k, 30);
        check(m, 30);
        check(n, 0);
        wr(8'h24, 32'h19);
        wr(8'h3c, 32'h40);
        trig_ext[7] <= 1'b1;
        repeat (20) @(posedge clock);
        wr(8'h00, 32'h0001007c);
        trig_ext[7] <= 1'b0;
        repeat (2) @(posedge clock);
        trig_ext[7] <= 1'b1;
        repeat (20) @(posedge clock);
        check(acq_busy[0], 1'b0);
        trig_ext[7] <= 1'b0;
        repeat (20) @(posedge clock);
        check({acq_busy[0], trig_out[1]}, 2'h3);
        wr(8'h40, 32'h00010034);
        trig_ext[6] <= 1'b1;
        repeat (20) @(posedge clock);
        check(acq_busy[1], 1'b1);
        wr(8'h00, 32'h2);
        wr(8'h40, 32'h2);
        repeat (3) @(posedge clock);
        check(acq_busy, 2'h0);
        wr(8'h84, 32'h4);
        repeat (10) step(2'h1);
        repeat (3) step(2'h3);
        check(np, 3);
        rchk(8'h88, 32'h7);
        rchk(8'h8c, 32'h0);
        wr(8'h80, 32'h3);
        rchk(8'h88, 32'h0);
        enc_a <= ~enc_a;
        repeat (3) @(posedge clock);
        rchk(8'h88, 32'h0);
        enc_a <= ~enc_a;
        repeat (20) @(posedge clock);
        step(2'h3);
        rchk(8'h88, 32'hffffffff);
        rchk(8'h8c, 32'hffffffff);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        check({trig_oe, acq_busy}, 10'h0);
        rchk(8'h08, 32'h90);
        rchk(8'h20, 32'h0);
        results();
    end
endmodule
`default_nettype wire
